// ==== core/mrr_cfg.svh ====
// Constants for the motion report register block: offsets, field positions,
// reset values and timing figures. Assumes a 100 MHz core clock.
// Summary of operation
// - A fixed eight-bit product identifier is readable to prove the serial link.
// - An eight-bit silicon version, any value 00 to FF, names the design revision.
// - Movement pending bit reads 1 when motion data awaits the host, else 0.
// - LED error bit sets on a bad LED resistor, supply short or ground short.
// - LED error bit is sticky and clears only on a motion status read.
// - LED drive resumes by itself once the LED fault goes away.
// - Wide X/Y accumulators; overflow sets the matching overrun bit, path lost.
// - Overrun bits clear only on a displacement read while that wide accumulator is off its saturation limit.
// - Resolution bit shows 0 for 400 cpi and 1 for 800 cpi.
// - A motion status read freezes X and Y displacement for later reads.
// - Read both displacements before next status read, else frozen values lost.
// - While residual motion remains, displacement reads give positive or negative full scale.
// - X displacement is eight-bit two's complement counts; reading it clears it.
// - Y displacement is eight-bit two's complement counts; reading it clears it.
// - Surface quality gives visible feature count, 0 to 255, near zero without surface.
`ifndef MRR_CFG_SVH
`define MRR_CFG_SVH

`define MRR_ADDR_PRODUCT   7'h00
`define MRR_ADDR_VERSION   7'h01
`define MRR_ADDR_STATUS    7'h02
`define MRR_ADDR_DX        7'h03
`define MRR_ADDR_DY        7'h04
`define MRR_ADDR_SQUAL     7'h05

`define MRR_BIT_PENDING    7
`define MRR_BIT_FAULT      5
`define MRR_BIT_OVY        4
`define MRR_BIT_OVX        3
`define MRR_BIT_CPI        0

`define MRR_RST_BYTE       8'h00
`define MRR_ACC_W          12
`define MRR_ACC_MAX        12'sh7ff
`define MRR_ACC_MIN        12'sh800
`define MRR_FS_POS         8'sh7f
`define MRR_FS_NEG         8'sh80

`define MRR_CLK_PERIOD_NS  10
`define MRR_T_ADDR_DATA_NS 100
`define MRR_ADDR_DATA_CYC  ((`MRR_T_ADDR_DATA_NS + `MRR_CLK_PERIOD_NS - 1) / `MRR_CLK_PERIOD_NS)

`endif

// ==== core/mrr_pkg.sv ====
// Types shared by the motion report register block.
// Assumes mrr_cfg.svh supplies the numeric constants.
package mrr_pkg;
	// One frame's displacement from the navigation engine
	typedef struct packed {
		logic             valid;
		logic signed [7:0] dx;
		logic signed [7:0] dy;
	} mrr_motion_t;

	// Sticky and live flags of the motion status byte
	typedef struct packed {
		logic pending;
		logic fault;
		logic ovy;
		logic ovx;
	} mrr_flags_t;

	typedef enum logic [2:0] {
		MRR_SER_ADDR  = 3'b001,
		MRR_SER_READ  = 3'b010,
		MRR_SER_WRITE = 3'b100
	} mrr_ser_state_t;
endpackage

// ==== core/mrr_top.sv ====
// Motion report registers with a two-wire serial port on its own clock.
// Assumes the navigation engine and LED monitor sit on ref_clk; sclk is host-driven.
`timescale 1ns/1ps
`include "mrr_cfg.svh"

module mrr_top
	import mrr_pkg::*;
#(
	parameter logic [7:0] PRODUCT_CODE = 8'h5a, // Arbitrary value
	parameter logic [7:0] VERSION_CODE = 8'h01  // Arbitrary value
) (
	input  wire logic        ref_clk,
	input  wire logic        resetn,
	input  wire logic        ce,
	input  wire mrr_motion_t motion_in,
	input  wire logic        cpi_800,
	input  wire logic        led_fault_in,
	input  wire logic [7:0]  squal_in,
	output logic             led_drive_q,
	input  wire logic        sclk,
	input  wire logic        sdio_in,
	output logic             sdio_out_q,
	output logic             sdio_oe_n_q
);

	// Serial side, clocked by the host's sclk
	mrr_ser_state_t    ser_state_q;
	logic [2:0]        ser_cnt_q;
	logic [6:0]        ser_sh_q;
	logic [6:0]        ser_addr_q;
	logic              ser_req_tgl_q;
	logic [6:0]        ser_dsh_q;

	// Core side
	logic [7:0]        rd_data_q;
	logic              req_s1_q;
	logic              req_s2_q;
	logic              req_s3_q;
	logic              req_evt;
	logic              st_rd;
	logic              dx_rd;
	logic              dy_rd;
	logic signed [`MRR_ACC_W-1:0] acc_x_q;
	logic signed [`MRR_ACC_W-1:0] acc_y_q;
	logic signed [`MRR_ACC_W-1:0] acc_x_d;
	logic signed [`MRR_ACC_W-1:0] acc_y_d;
	logic signed [7:0] frz_x_q;
	logic signed [7:0] frz_y_q;
	logic signed [7:0] take_x;
	logic signed [7:0] take_y;
	logic              ovf_x;
	logic              ovf_y;
	mrr_flags_t        flags_q;
	logic              cpi_q;
	logic [7:0]        squal_q;
	logic [7:0]        status_byte;

	// Clamp a wide accumulator to an eight-bit report
	function automatic logic signed [7:0] clamp8(input logic signed [`MRR_ACC_W-1:0] a);
		if (a > `MRR_ACC_W'(signed'(`MRR_FS_POS)))
			return `MRR_FS_POS;
		else if (a < `MRR_ACC_W'(signed'(`MRR_FS_NEG)))
			return `MRR_FS_NEG;
		else
			return a[7:0];
	endfunction

	// Saturating accumulate; flags overflow when the wide range is exceeded
	function automatic logic [`MRR_ACC_W:0] accum(input logic signed [`MRR_ACC_W-1:0] a,
		input logic signed [7:0] inc, input logic signed [7:0] dec);
		logic signed [`MRR_ACC_W+1:0] s;
		s = (`MRR_ACC_W+2)'(a) + (`MRR_ACC_W+2)'(inc) - (`MRR_ACC_W+2)'(dec);
		if (s > (`MRR_ACC_W+2)'(`MRR_ACC_MAX))
			return {1'b1, `MRR_ACC_MAX};
		else if (s < (`MRR_ACC_W+2)'(`MRR_ACC_MIN))
			return {1'b1, `MRR_ACC_MIN};
		else
			return {1'b0, s[`MRR_ACC_W-1:0]};
	endfunction

	// Serial frame: 8 address bits (MSB = write), then 8 data bits
	always_ff @(posedge sclk or negedge resetn) begin
		if (!resetn) begin
			ser_state_q   <= MRR_SER_ADDR;
			ser_cnt_q     <= 3'h0;
			ser_sh_q      <= 7'h00;
			ser_addr_q    <= 7'h00;
			ser_req_tgl_q <= 1'b0;
			ser_dsh_q     <= 7'h00;
			sdio_out_q    <= 1'b0;
			sdio_oe_n_q   <= 1'b1;
		end else begin
			ser_cnt_q <= ser_cnt_q + 3'h1;
			case (ser_state_q)
				MRR_SER_ADDR: begin
					sdio_oe_n_q <= 1'b1;
					ser_sh_q    <= {ser_sh_q[5:0], sdio_in};
					if (ser_cnt_q == 3'h7) begin
						ser_addr_q <= {ser_sh_q[5:0], sdio_in};
						if (ser_sh_q[6]) begin
							ser_state_q <= MRR_SER_WRITE;
						end else begin
							ser_req_tgl_q <= ~ser_req_tgl_q;
							ser_state_q   <= MRR_SER_READ;
						end
					end
				end
				MRR_SER_READ: begin
					// No handshake: rd_data_q is settled by the required address-data gap
					sdio_oe_n_q <= 1'b0;
					if (ser_cnt_q == 3'h0) begin
						sdio_out_q <= rd_data_q[7];
						ser_dsh_q  <= rd_data_q[6:0];
					end else begin
						sdio_out_q <= ser_dsh_q[6];
						ser_dsh_q  <= {ser_dsh_q[5:0], 1'b0};
					end
					if (ser_cnt_q == 3'h7)
						ser_state_q <= MRR_SER_ADDR;
				end
				MRR_SER_WRITE: begin
					if (ser_cnt_q == 3'h7)
						ser_state_q <= MRR_SER_ADDR;
				end
				default: begin
					ser_state_q <= MRR_SER_ADDR;
				end
			endcase
		end
	end

	// Request toggle crosses into ref_clk through two flops
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			req_s1_q <= 1'b0;
			req_s2_q <= 1'b0;
			req_s3_q <= 1'b0;
		end else if (ce) begin
			req_s1_q <= ser_req_tgl_q;
			req_s2_q <= req_s1_q;
			req_s3_q <= req_s2_q;
		end
	end

	// Address is stable from the toggle until the next frame's address completes
	assign req_evt = ce && (req_s2_q != req_s3_q);
	assign st_rd   = req_evt && (ser_addr_q == `MRR_ADDR_STATUS);
	assign dx_rd   = req_evt && (ser_addr_q == `MRR_ADDR_DX);
	assign dy_rd   = req_evt && (ser_addr_q == `MRR_ADDR_DY);

	// freeze takes at most full scale, remainder stays queued
	assign take_x = clamp8(acc_x_q);
	assign take_y = clamp8(acc_y_q);

	always_comb begin
		logic [`MRR_ACC_W:0] rx;
		logic [`MRR_ACC_W:0] ry;
		rx = accum(acc_x_q, motion_in.valid ? motion_in.dx : 8'sh00, st_rd ? take_x : 8'sh00);
		ry = accum(acc_y_q, motion_in.valid ? motion_in.dy : 8'sh00, st_rd ? take_y : 8'sh00);
		acc_x_d = rx[`MRR_ACC_W-1:0];
		acc_y_d = ry[`MRR_ACC_W-1:0];
		ovf_x   = rx[`MRR_ACC_W];
		ovf_y   = ry[`MRR_ACC_W];
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			acc_x_q <= '0;
			acc_y_q <= '0;
		end else if (ce) begin
			acc_x_q <= acc_x_d;
			acc_y_q <= acc_y_d;
		end
	end

	// Displacement holding registers
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			frz_x_q <= 8'sh00;
			frz_y_q <= 8'sh00;
		end else if (ce) begin
			// status read freezes; unread values are overwritten
			if (st_rd) begin
				frz_x_q <= take_x;
				frz_y_q <= take_y;
			end else begin
				if (dx_rd)
					frz_x_q <= 8'sh00;
				if (dy_rd)
					frz_y_q <= 8'sh00;
			end
		end
	end

	// Sticky flags; a new event wins over the clear in the same cycle
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			flags_q <= '0;
		end else if (ce) begin
			flags_q.fault <= led_fault_in || (flags_q.fault && !st_rd);
			flags_q.ovx <= ovf_x || (flags_q.ovx &&
				!(dx_rd && acc_x_q != `MRR_ACC_MAX && acc_x_q != `MRR_ACC_MIN));
			flags_q.ovy <= ovf_y || (flags_q.ovy &&
				!(dy_rd && acc_y_q != `MRR_ACC_MAX && acc_y_q != `MRR_ACC_MIN));
			// pending while anything is queued or frozen
			flags_q.pending <= (acc_x_d != '0) || (acc_y_d != '0) ||
				(st_rd ? (take_x != 8'sh00 || take_y != 8'sh00) :
				((frz_x_q != 8'sh00 && !dx_rd) || (frz_y_q != 8'sh00 && !dy_rd)));
		end
	end

	// Live inputs registered; LED drive follows the fault with no host action
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			cpi_q       <= 1'b0;
			squal_q     <= 8'h00;
			led_drive_q <= 1'b0;
		end else if (ce) begin
			cpi_q       <= cpi_800;
			squal_q     <= squal_in;
			led_drive_q <= !led_fault_in;
		end
	end

	// status byte with reserved bits at zero
	always_comb begin
		status_byte                   = 8'h00;
		status_byte[`MRR_BIT_PENDING] = flags_q.pending;
		status_byte[`MRR_BIT_FAULT]   = flags_q.fault;
		status_byte[`MRR_BIT_OVY]     = flags_q.ovy;
		status_byte[`MRR_BIT_OVX]     = flags_q.ovx;
		status_byte[`MRR_BIT_CPI]     = cpi_q;
	end

	// Read data is latched once per request and held for the serial side
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			rd_data_q <= `MRR_RST_BYTE;
		end else if (req_evt) begin
			case (ser_addr_q)
				`MRR_ADDR_PRODUCT: rd_data_q <= PRODUCT_CODE;
				`MRR_ADDR_VERSION: rd_data_q <= VERSION_CODE;
				`MRR_ADDR_STATUS:  rd_data_q <= status_byte;
				`MRR_ADDR_DX:      rd_data_q <= frz_x_q;
				`MRR_ADDR_DY:      rd_data_q <= frz_y_q;
				`MRR_ADDR_SQUAL:   rd_data_q <= squal_q;
				default:           rd_data_q <= 8'h00;
			endcase
		end
	end

	// Checks on the core side
	sequence s_fault_seen;
		ce && led_fault_in;
	endsequence

	property p_fault_sticky;
		@(posedge ref_clk) disable iff (!resetn)
		flags_q.fault && !st_rd && ce |=> flags_q.fault;
	endproperty
	a_fault_sticky: assert property (p_fault_sticky) else $error("fault flag dropped");

	property p_fault_set;
		@(posedge ref_clk) disable iff (!resetn)
		s_fault_seen |=> flags_q.fault;
	endproperty
	a_fault_set: assert property (p_fault_set) else $error("fault not latched");

	property p_fault_clear;
		@(posedge ref_clk) disable iff (!resetn)
		st_rd && !led_fault_in |=> !flags_q.fault;
	endproperty
	a_fault_clear: assert property (p_fault_clear) else $error("fault not cleared");

	property p_led_resume;
		@(posedge ref_clk) disable iff (!resetn)
		s_fault_seen ##1 (ce && !led_fault_in) |=> led_drive_q;
	endproperty
	a_led_resume: assert property (p_led_resume) else $error("LED not resumed");

	property p_freeze;
		@(posedge ref_clk) disable iff (!resetn)
		st_rd |=> frz_x_q == $past(take_x) && frz_y_q == $past(take_y);
	endproperty
	a_freeze: assert property (p_freeze) else $error("freeze value wrong");

	property p_dx_clear;
		@(posedge ref_clk) disable iff (!resetn)
		dx_rd |=> frz_x_q == 8'sh00 && rd_data_q == $past(frz_x_q);
	endproperty
	a_dx_clear: assert property (p_dx_clear) else $error("X read not clearing");

	property p_dy_clear;
		@(posedge ref_clk) disable iff (!resetn)
		dy_rd |=> frz_y_q == 8'sh00 && rd_data_q == $past(frz_y_q);
	endproperty
	a_dy_clear: assert property (p_dy_clear) else $error("Y read not clearing");

	property p_ovx_set;
		@(posedge ref_clk) disable iff (!resetn)
		ce && ovf_x |=> flags_q.ovx && (acc_x_q == `MRR_ACC_MAX || acc_x_q == `MRR_ACC_MIN);
	endproperty
	a_ovx_set: assert property (p_ovx_set) else $error("X overrun not set");

	property p_status_byte;
		@(posedge ref_clk) disable iff (!resetn)
		st_rd |=> rd_data_q[6] == 1'b0 && rd_data_q[2:1] == 2'b00
			&& rd_data_q[0] == $past(cpi_q);
	endproperty
	a_status_byte: assert property (p_status_byte) else $error("status byte wrong");

	property p_full_scale;
		@(posedge ref_clk) disable iff (!resetn)
		st_rd && (acc_x_q > 12'sh07f) |=> frz_x_q == `MRR_FS_POS && flags_q.pending;
	endproperty
	a_full_scale: assert property (p_full_scale) else $error("no full scale");

	property p_ovy_set;
		@(posedge ref_clk) disable iff (!resetn)
		ce && ovf_y |=> flags_q.ovy && (acc_y_q == `MRR_ACC_MAX || acc_y_q == `MRR_ACC_MIN);
	endproperty
	a_ovy_set: assert property (p_ovy_set) else $error("Y overrun not set");

	property p_ovx_clear;
		@(posedge ref_clk) disable iff (!resetn)
		dx_rd && !ovf_x && acc_x_q != `MRR_ACC_MAX && acc_x_q != `MRR_ACC_MIN
			|=> !flags_q.ovx;
	endproperty
	a_ovx_clear: assert property (p_ovx_clear) else $error("X overrun not cleared");

	// Nothing queued, nothing frozen, no new frame: pending must drop
	property p_pending_idle;
		@(posedge ref_clk) disable iff (!resetn)
		ce && acc_x_q == '0 && acc_y_q == '0 && frz_x_q == 8'sh00 && frz_y_q == 8'sh00
			&& !motion_in.valid |=> !flags_q.pending;
	endproperty
	a_pending_idle: assert property (p_pending_idle) else $error("pending stuck");

	property p_pending_motion;
		@(posedge ref_clk) disable iff (!resetn)
		ce && motion_in.valid && motion_in.dx != 8'sh00 && acc_x_q == '0
			|=> flags_q.pending;
	endproperty
	a_pending_motion: assert property (p_pending_motion) else $error("pending missed");

endmodule // mrr_top

// ==== testbench/mrr_host.sv ====
// Host partner: clocks serial frames on sclk and reads or writes one byte.
// Assumes the bench joins dout/oe_n to the device and feeds sdio to it.
`timescale 1ns/1ps
module mrr_host (
	output logic       sclk,
	output wire logic  sdio,
	input  wire logic  dout,
	input  wire logic  oe_n,
	output logic       done,
	output logic [7:0] rbyte
);
	logic hb;
	logic hd;
	// Host takes the line from frame start: the device still drives until edge 1
	assign sdio = (hd || oe_n) ? hb : dout;
	initial begin
		sclk = 1'b0;
		hb = 1'b0;
		hd = 1'b0;
		done = 1'b0;
		rbyte = 8'h00;
	end
	// Clock stands low between frames
	task automatic xfer(input logic w, input logic [6:0] a, input logic [7:0] wd);
		logic [7:0] ab;
		ab = {w, a};
		#3;
		hd = 1'b1;
		for (int i = 7; i >= 0; i--) begin
			hb = ab[i];
			#24 sclk = 1'b1;
			#24 sclk = 1'b0;
		end
		// Released line must not keep the last bit
		hb = ~hb;
		hd = w;
		#120;
		for (int i = 7; i >= 0; i--) begin
			hb = w ? wd[i] : ~hb;
			#24 sclk = 1'b1;
			#2 rbyte[i] = sdio;
			#22 sclk = 1'b0;
		end
		hb = ~hb;
		hd = 1'b0;
		if (!w) begin
			done = 1'b1;
			#1 done = 1'b0;
		end
	endtask
endmodule // mrr_host

// ==== testbench/tb_top.sv ====
// Self-checking bench for the motion report registers.
// Assumes mrr_host as serial partner; expectations come from a small model.
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin errors++; \
	$display("Error %0t: got %h exp %h", $time, g, e); end end
module tb_top;
	import mrr_pkg::*;
	localparam logic [7:0] PCODE = 8'h3c; // Arbitrary value
	localparam logic [7:0] VCODE = 8'hc3; // Arbitrary value
	logic        ref_clk = 1'b0;
	logic        resetn = 1'b0;
	logic        ce = 1'b1;
	logic        cpi_800 = 1'b0;
	logic        fault = 1'b0;
	logic [7:0]  squal = 8'h00;
	mrr_motion_t motion = '0;
	wire logic   sclk, sdio, dout, oe_n, drv, done;
	logic [7:0]  rbyte, e;
	logic [7:0]  q[$];
	logic [31:0] rs = 32'habc5;
	int          errors = 0, n_compared = 0, ax = 0, ay = 0, fx = 0, fy = 0, v;
	bit          ox, oy, fl;

	always #5 ref_clk = ~ref_clk;

	mrr_top #(.PRODUCT_CODE(PCODE), .VERSION_CODE(VCODE)) mrr_top_inst (
		.ref_clk(ref_clk), .resetn(resetn), .ce(ce), .motion_in(motion),
		.cpi_800(cpi_800), .led_fault_in(fault), .squal_in(squal),
		.led_drive_q(drv), .sclk(sclk), .sdio_in(sdio), .sdio_out_q(dout),
		.sdio_oe_n_q(oe_n));
	mrr_host mrr_host_inst (.sclk(sclk), .sdio(sdio), .dout(dout), .oe_n(oe_n),
		.done(done), .rbyte(rbyte));

	function logic [31:0] nxt();
		rs ^= rs << 13;
		rs ^= rs >> 17;
		rs ^= rs << 5;
		return rs;
	endfunction
	function automatic int clp(input int x, input int lo, input int hi);
		return x > hi ? hi : (x < lo ? lo : x);
	endfunction

	// Oldest note against each read result
	always @(posedge done) begin
		e = q.pop_front();
		`CHK(rbyte, e)
	end

	task rd(input logic [6:0] a, input logic [7:0] x);
		q.push_back(x);
		mrr_host_inst.xfer(1'b0, a, 8'h00);
	endtask
	task mv(input int x, input int y);
		@(posedge ref_clk);
		motion <= {1'b1, x[7:0], y[7:0]};
		@(posedge ref_clk);
		motion.valid <= 1'b0;
		ox |= (ax + x > 2047) || (ax + x < -2048);
		oy |= (ay + y > 2047) || (ay + y < -2048);
		ax = clp(ax + x, -2048, 2047);
		ay = clp(ay + y, -2048, 2047);
	endtask
	// Status read freezes and drains the accumulators
	task st();
		rd(7'h02, {(ax | ay | fx | fy) != 0, 1'b0, fl, oy, ox, 2'b00, cpi_800});
		fl = 0;
		fx = clp(ax, -128, 127);
		fy = clp(ay, -128, 127);
		ax -= fx;
		ay -= fy;
	endtask
	task rx(input bit y);
		if (y) begin
			rd(7'h04, fy[7:0]);
			fy = 0;
			oy &= (ay == 2047 || ay == -2048);
		end else begin
			rd(7'h03, fx[7:0]);
			fx = 0;
			ox &= (ax == 2047 || ax == -2048);
		end
	endtask
	task cyc();
		st();
		rx(0);
		rx(1);
	endtask
	task end_of_test();
		$display("compared %0d errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	initial begin
		#400us;
		errors++;
		$display("Error %0t: watchdog expired", $time);
		end_of_test();
	end

	initial begin
		repeat (3) @(posedge ref_clk);
		resetn <= 1'b1;
		v = nxt();
		squal <= v[7:0];
		repeat (3) @(posedge ref_clk);
		rd(7'h00, PCODE);
		rd(7'h01, VCODE);
		rd(7'h05, squal);
		rd(7'h06, 8'h00);
		cyc();
		// Writes are ignored
		mrr_host_inst.xfer(1'b1, 7'h03, 8'h55);
		mrr_host_inst.xfer(1'b1, 7'h02, 8'hff);
		rd(7'h03, 8'h00);
		// Clock enable low drops this frame's motion
		@(posedge ref_clk);
		ce <= 1'b0;
		motion <= {1'b1, 8'h09, 8'h09};
		@(posedge ref_clk);
		motion.valid <= 1'b0;
		ce <= 1'b1;
		mv(5, -3);
		cyc();
		cyc();
		mv(4, 0);
		st();
		mv(10, 0);
		rx(0);
		rx(1);
		cyc();
		mv(7, 1);
		st();
		mv(2, 0);
		st();
		rx(0);
		rx(1);
		@(posedge ref_clk);
		fault <= 1'b1;
		repeat (4) @(posedge ref_clk);
		fault <= 1'b0;
		#1;
		`CHK(drv, 1'b0)
		fl = 1;
		repeat (3) @(posedge ref_clk);
		#1;
		`CHK(drv, 1'b1)
		st();
		st();
		@(posedge ref_clk);
		cpi_800 <= 1'b1;
		repeat (24) begin
			v = 100 + nxt() % 28;
			mv(v, -v);
		end
		// Bounded drain of saturated accumulators
		for (int k = 0; k < 40 && (ax | ay | fx | fy) != 0; k++)
			cyc();
		if ((ax | ay | fx | fy) != 0) begin
			errors++;
			$display("Error %0t: drain limit reached", $time);
		end
		cyc();
		#100;
		`CHK(q.size(), 0)
		end_of_test();
	end
endmodule // tb_top
